// File: rtl/cpad_datapath.sv
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module cpad_datapath (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [cpad_pkg::WB_ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire cpad_pkg::cpad_instr_type          instr_i,
  input  wire logic [7:0]                        file_rdata_i,
  output logic                                   file_we_o,
  output logic      [cpad_pkg::FILE_ADDR_W-1:0]  file_addr_o,
  output logic      [7:0]                        file_wdata_o,
  output logic                                   done_o
);

  cpad_pkg::cpad_state_type q;
  cpad_pkg::cpad_state_type d;

  // Returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] status_word(input cpad_pkg::cpad_state_type s);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[cpad_pkg::STAT_CARRY_BIT]       = s.carry;
    r[cpad_pkg::STAT_DIGIT_CARRY_BIT] = s.digit_carry_flag;
    r[cpad_pkg::STAT_ZERO_BIT]        = s.zero;
    return r;
  endfunction

  logic [9:0]                   sum;
  logic [7:0]                   result;
  logic                         to_dest;
  logic [cpad_pkg::PTR_W-1:0]   ptr_sel_val;
  logic [cpad_pkg::PTR_W-1:0]   ptr_sum;
  logic [31:0]                  merged;
  logic                         bus_req;
  logic                         bus_wr;

  always_comb begin
    d = q;
    d.file_we = 1'b0;
    d.done = 1'b0;
    sum = 10'h000;
    result = 8'h00;
    to_dest = 1'b0;
    ptr_sel_val = instr_i.ptr_sel ? q.indirect_pointer1 : q.indirect_pointer0;
    ptr_sum = ptr_sel_val
            + {{(cpad_pkg::PTR_W-cpad_pkg::PTR_LIT_W){instr_i.literal[cpad_pkg::PTR_LIT_W-1]}},
               instr_i.literal[cpad_pkg::PTR_LIT_W-1:0]};
    merged = 32'h0000_0000;

    // Bus slave: ack one cycle after request, write commits while ack is high
    bus_req = wb_cyc_i && wb_stb_i;
    bus_wr = bus_req && wb_we_i && q.ack;
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      case (wb_adr_i)
        cpad_pkg::OFS_WORKING:  d.rdata = {24'h000000, q.working};
        cpad_pkg::OFS_STATUS:   d.rdata = status_word(q);
        cpad_pkg::OFS_POINTER0: d.rdata = {16'h0000, q.indirect_pointer0};
        cpad_pkg::OFS_POINTER1: d.rdata = {16'h0000, q.indirect_pointer1};
        default:                d.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      case (wb_adr_i)
        cpad_pkg::OFS_WORKING: begin
          merged = lane_merge({24'h000000, q.working}, wb_dat_i, wb_sel_i);
          d.working = merged[7:0];
        end
        cpad_pkg::OFS_STATUS: begin
          merged = lane_merge(status_word(q), wb_dat_i, wb_sel_i);
          d.carry = merged[cpad_pkg::STAT_CARRY_BIT];
          d.digit_carry_flag = merged[cpad_pkg::STAT_DIGIT_CARRY_BIT];
          d.zero = merged[cpad_pkg::STAT_ZERO_BIT];
        end
        cpad_pkg::OFS_POINTER0: begin
          merged = lane_merge({16'h0000, q.indirect_pointer0}, wb_dat_i, wb_sel_i);
          d.indirect_pointer0 = merged[15:0];
        end
        cpad_pkg::OFS_POINTER1: begin
          merged = lane_merge({16'h0000, q.indirect_pointer1}, wb_dat_i, wb_sel_i);
          d.indirect_pointer1 = merged[15:0];
        end
        default: begin
          merged = 32'h0000_0000;
        end
      endcase
    end

    // Execution overrides a bus write to the same state in the same cycle
    if (instr_i.valid) begin
      d.done = 1'b1;
      case (instr_i.op)
        cpad_pkg::CPAD_OP_POINTER_ADD_LITERAL: begin
          if (instr_i.ptr_sel) begin
            d.indirect_pointer1 = ptr_sum;
          end else begin
            d.indirect_pointer0 = ptr_sum;
          end
        end
        cpad_pkg::CPAD_OP_AND_LITERAL: begin
          result = q.working & instr_i.literal;
          d.working = result;
          d.zero = is_zero(result);
        end
        cpad_pkg::CPAD_OP_ADD_LITERAL: begin
          sum = add8(q.working, instr_i.literal, 1'b0);
          d.working = sum[7:0];
          d.carry = sum[9];
          d.digit_carry_flag = sum[8];
          d.zero = is_zero(sum[7:0]);
        end
        cpad_pkg::CPAD_OP_AND_FILE: begin
          result = q.working & file_rdata_i;
          to_dest = 1'b1;
          d.zero = is_zero(result);
        end
        cpad_pkg::CPAD_OP_ADD_FILE,
        cpad_pkg::CPAD_OP_ADD_FILE_WITH_CARRY: begin
          sum = add8(q.working, file_rdata_i,
                     (instr_i.op == cpad_pkg::CPAD_OP_ADD_FILE_WITH_CARRY) && q.carry);
          result = sum[7:0];
          to_dest = 1'b1;
          d.carry = sum[9];
          d.digit_carry_flag = sum[8];
          d.zero = is_zero(sum[7:0]);
        end
        cpad_pkg::CPAD_OP_ARITH_SHIFT_RIGHT: begin
          result = {file_rdata_i[7], file_rdata_i[7:1]};
          to_dest = 1'b1;
          d.carry = file_rdata_i[0];
          d.zero = is_zero(result);
        end
        default: begin
          d.done = 1'b0;
        end
      endcase
      if (to_dest) begin
        if (instr_i.dest == cpad_pkg::DEST_FILE) begin
          d.file_we = 1'b1;
          d.file_addr = instr_i.file_addr;
          d.file_wdata = result;
        end else begin
          d.working = result;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '{working:           cpad_pkg::RST_WORKING,
             carry:             cpad_pkg::RST_FLAG,
             digit_carry_flag:  cpad_pkg::RST_FLAG,
             zero:              cpad_pkg::RST_FLAG,
             indirect_pointer0: cpad_pkg::RST_POINTER,
             indirect_pointer1: cpad_pkg::RST_POINTER,
             ack:               1'b0,
             rdata:             32'h0000_0000,
             file_we:           1'b0,
             file_addr:         7'h00,
             file_wdata:        8'h00,
             done:              1'b0};
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o     = q.rdata;
  assign wb_ack_o     = q.ack;
  assign file_we_o    = q.file_we;
  assign file_addr_o  = q.file_addr;
  assign file_wdata_o = q.file_wdata;
  assign done_o       = q.done;

endmodule

// File: common/cpad_pkg.sv
package cpad_pkg;

  typedef enum logic [2:0] {
    CPAD_OP_NONE,
    CPAD_OP_POINTER_ADD_LITERAL,
    CPAD_OP_AND_LITERAL,
    CPAD_OP_ADD_LITERAL,
    CPAD_OP_AND_FILE,
    CPAD_OP_ADD_FILE,
    CPAD_OP_ARITH_SHIFT_RIGHT,
    CPAD_OP_ADD_FILE_WITH_CARRY
  } cpad_op_type;

  localparam int unsigned FILE_ADDR_W = 7;
  localparam int unsigned LIT_W       = 8;
  localparam int unsigned PTR_LIT_W   = 6;
  localparam int unsigned PTR_W       = 16;
  localparam int unsigned WB_ADR_W    = 8;

  // Destination select encoding
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE    = 1'b1;

  // Register byte offsets
  localparam logic [WB_ADR_W-1:0] OFS_WORKING  = 8'h00;
  localparam logic [WB_ADR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [WB_ADR_W-1:0] OFS_POINTER0 = 8'h08;
  localparam logic [WB_ADR_W-1:0] OFS_POINTER1 = 8'h0c;

  // Status field positions
  localparam int unsigned STAT_CARRY_BIT       = 0;
  localparam int unsigned STAT_DIGIT_CARRY_BIT = 1;
  localparam int unsigned STAT_ZERO_BIT        = 2;

  // Reset values
  localparam logic [7:0]       RST_WORKING = 8'h00;
  localparam logic [PTR_W-1:0] RST_POINTER = 16'h0000;
  localparam logic             RST_FLAG    = 1'b0;

  typedef struct packed {
    logic                   valid;
    cpad_op_type            op;
    logic [LIT_W-1:0]       literal;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic                   dest;
    logic                   ptr_sel;
  } cpad_instr_type;

  typedef struct packed {
    logic [7:0]             working;
    logic                   carry;
    logic                   digit_carry_flag;
    logic                   zero;
    logic [PTR_W-1:0]       indirect_pointer0;
    logic [PTR_W-1:0]       indirect_pointer1;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   file_we;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic [7:0]             file_wdata;
    logic                   done;
  } cpad_state_type;

endpackage

// File: dv/cpad_file_model.sv
`timescale 1ns/1ps
module cpad_file_model (
  input  wire logic       clk,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       we,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data
);
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
  end
  assign rd_data = mem[rd_addr];
  // Plain always: the array is also preloaded by the initial block
  always @(posedge clk) begin
    if (we) mem[wr_addr] <= wr_data;
  end
endmodule

// File: dv/cpad_datapath_asserts.sv
`timescale 1ns/1ps
module cpad_datapath_asserts (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire cpad_pkg::cpad_instr_type instr_i,
  input wire logic [7:0]               file_rdata_i,
  input wire logic                     file_we_o,
  input wire logic [6:0]               file_addr_o,
  input wire logic [7:0]               file_wdata_o,
  input wire logic                     done_o
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire v  = instr_i.valid && instr_i.op != cpad_pkg::CPAD_OP_NONE;
  wire fw = instr_i.valid && instr_i.op[2] && instr_i.dest;
  wire fd = instr_i.valid && instr_i.op[2] && !instr_i.dest;
  a_done_pulse: assert property (v |=> done_o)
    else $error("done pulse missing");
  a_no_done: assert property (!v |=> !done_o)
    else $error("done without instruction");
  a_file_dest: assert property (fw |=>
    file_we_o && file_addr_o == $past(instr_i.file_addr)) else $error("file write wrong");
  a_work_dest: assert property (fd |=> !file_we_o)
    else $error("file written for working destination");
  a_lit_nowrite: assert property (instr_i.valid && !instr_i.op[2] |=> !file_we_o)
    else $error("literal op wrote file");
  a_we_cause: assert property (file_we_o |-> $past(fw))
    else $error("file write without cause");
  a_shift_msb: assert property (fw && instr_i.op == 3'h6 |=>
    file_wdata_o == {$past(file_rdata_i[7]), $past(file_rdata_i[7:1])}) else $error("shift bad");
  a_and_mask: assert property (fw && instr_i.op == 3'h4 |=>
    (file_wdata_o & ~$past(file_rdata_i)) == 8'h00) else $error("and result bad");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  c_file_write: cover property (fw ##1 file_we_o);
  c_refused_op: cover property (instr_i.valid && !v);
  c_bus_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind cpad_datapath cpad_datapath_asserts u_chk (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_i, .file_rdata_i,
  .file_we_o, .file_addr_o, .file_wdata_o, .done_o);

// File: dv/cpad_datapath_bench.sv
`timescale 1ns/1ps
module cpad_datapath_bench;
  logic                     clk, rst_b, cyc, stb, we, ack, fwe, done, c, dc, z;
  logic [7:0]               adr, fwd, frd, w;
  logic [31:0]              dat, rdo, q;
  logic [3:0]               sel;
  logic [6:0]               fa;
  logic [15:0]              p [2];
  logic [7:0]               sh [128];
  cpad_pkg::cpad_instr_type ins;
  int                       n_fail = 0;
  int                       cmp_count = 0;
  cpad_datapath dut (.clk, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .instr_i(ins), .file_rdata_i(frd), .file_we_o(fwe), .file_addr_o(fa),
    .file_wdata_o(fwd), .done_o(done));
  cpad_file_model fm (.clk, .rd_addr(ins.file_addr), .rd_data(frd), .we(fwe),
    .wr_addr(fa), .wr_data(fwd));
  task automatic conclude;
    $display("mismatches=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, wr, a, d};
    for (n = 0; n < 9 && ack !== 1'b1; n++) @(posedge clk);
    if (n == 9) begin
      n_fail++;
      conclude();
    end
    q = rdo;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ex(input cpad_pkg::cpad_op_type op, input logic [7:0] k,
                    input logic [6:0] a, input logic d, input logic s);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] b, r;
    logic       ci, wr, ad;
    b = op[2] ? sh[a] : k;
    ci = op == 3'h7 && c;
    t = {1'b0, w} + b + ci;
    h = w[3:0] + b[3:0] + ci;
    ad = op inside {3, 5, 7};
    wr = op[2] && d;
    r = ad ? t[7:0] : op == 3'h6 ? {b[7], b[7:1]} : w & b;
    if (ad) {c, dc} = {t[8], h[4]};
    if (op == 3'h6) c = b[0];
    if (op > 3'h1) z = r == 8'h00;
    if (op == 3'h1) p[s] = p[s] + {{10{k[5]}}, k[5:0]};
    else if (wr) sh[a] = r;
    else if (op > 3'h1) w = r;
    @(posedge clk);
    ins <= '{1'b1, op, k, a, d, s};
    @(posedge clk);
    ins.valid <= 1'b0;
    #1;
    chk(done, op != 3'h0);
    chk(fwe, wr);
    if (wr) chk({fa, fwd}, {a, r});
    rd(8'h00, w);
    rd(8'h04, {z, dc, c});
    rd(s ? 8'h0c : 8'h08, p[s]);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_b, cyc, stb, we, adr, dat, ins, w, c, dc, z} = '0;
    sel = 4'hf;
    for (int i = 0; i < 128; i++) sh[i] = 8'(i * 37 + 5);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, then the unmapped slot at 0x10
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
    wb(1'b1, 8'h10, 32'h5a);
    rd(8'h10, 32'h0);
    wb(1'b1, 8'h04, 32'hffff_ffff);
    {z, dc, c} = 3'h7;
    rd(8'h04, 32'h7);
    wb(1'b1, 8'h00, 32'hc8);
    wb(1'b1, 8'h08, 32'hfffa);
    wb(1'b1, 8'h0c, 32'h5);
    w = 8'hc8;
    p = '{16'hfffa, 16'h0005};
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) begin
        ex(cpad_pkg::cpad_op_type'(3'(i)), 8'(i * 53 + j * 97), 7'(i * 9 + j), j[0], j[1]);
      end
    end
    // Byte lanes: only lane 1 of pointer 0 changes
    sel <= 4'h2;
    wb(1'b1, 8'h08, 32'h1234_ab56);
    sel <= 4'hf;
    p[0][15:8] = 8'hab;
    rd(8'h08, p[0]);
    // Instruction and bus write hit the working register in one cycle
    fork
      wb(1'b1, 8'h00, 32'h11);
      begin
        repeat (2) @(posedge clk);
        ins <= '{1'b1, cpad_pkg::CPAD_OP_AND_LITERAL, 8'h0f, 7'h00, 1'b0, 1'b0};
        @(posedge clk);
        ins.valid <= 1'b0;
      end
    join
    w = w & 8'h0f;
    z = w == 8'h00;
    rd(8'h00, w);
    rd(8'h04, {z, dc, c});
    // Second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk(done, 1'b0);
    chk(fwe, 1'b0);
    {w, c, dc, z} = '0;
    p = '{16'h0000, 16'h0000};
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 128; i++) chk(fm.mem[i], sh[i]);
    conclude();
  end
endmodule
